// >>> rtl/fess_map.vh
`ifndef FESS_MAP_VH
`define FESS_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define FESS_REG_ADDR    8'h00
`define FESS_REG_CMD     8'h04
`define FESS_REG_RDATA   8'h08
`define FESS_REG_STATE   8'h0c

////////////////////////////////////////////////////////////////////////////////
// state register fields
`define FESS_ST_CODE_LSB 0
`define FESS_ST_READY    4
`define FESS_ST_DAMAGED  5
`define FESS_ST_MASK_LSB 8

////////////////////////////////////////////////////////////////////////////////
// status byte bit positions
`define FESS_B_POLL      7
`define FESS_B_TOGGLE    6
`define FESS_B_TLIM      5
`define FESS_B_WIN       3
`define FESS_B_STOG      2

////////////////////////////////////////////////////////////////////////////////
// command sequence addresses and codes
`define FESS_UNLK_A1     16'h0aaa
`define FESS_UNLK_A2     16'h0554
`define FESS_CD_UNLK1    8'haa
`define FESS_CD_UNLK2    8'h55
`define FESS_CD_ERASE    8'h80
`define FESS_CD_PROG     8'ha0
`define FESS_CD_CHIP     8'h10
`define FESS_CD_SECT     8'h30
`define FESS_CD_SUSP     8'hb0
`define FESS_CD_RESET    8'hf0

////////////////////////////////////////////////////////////////////////////////
// timing
`define FESS_CLK_MHZ     24'h64
`define FESS_CLK_NS      10
`define FESS_WIN_US      24'h32
`define FESS_REINIT_US   20
`define FESS_RST_IDLE_NS 500
`define FESS_RST_BUSY_NS 50
`define FESS_PROG_CYC    24'h3e8
`define FESS_PRE_CYC     24'h4e20
`define FESS_ERASE_CYC   24'h4e20

`endif

// >>> rtl/fess_axil.v
`timescale 1ns/1ps
`default_nettype none
module fess_axil #(
  parameter ADDR_W = 8
) (
  input  wire              sys_clk,
  input  wire              reset,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  output wire              wrStb,
  output wire [ADDR_W-1:0] wrAddr,
  output wire [31:0]       wrData,
  output wire [3:0]        wrStrb,
  input  wire              wrErr,
  output wire              rdStb,
  output wire [ADDR_W-1:0] rdAddr,
  input  wire [31:0]       rdWord,
  input  wire              rdErr
);
  reg              awHeld;
  reg              wHeld;
  reg [ADDR_W-1:0] awA;
  reg [31:0]       wD;
  reg [3:0]        wS;

  assign s_axi_awready = !awHeld;
  assign s_axi_wready  = !wHeld;
  assign s_axi_arready = !s_axi_rvalid;
  assign wrStb  = awHeld && wHeld && !s_axi_bvalid;
  assign wrAddr = awA;
  assign wrData = wD;
  assign wrStrb = wS;
  assign rdStb  = s_axi_arvalid && !s_axi_rvalid;
  assign rdAddr = s_axi_araddr;

  always @(posedge sys_clk) begin
    if (reset) begin
      awHeld       <= 1'b0;
      wHeld        <= 1'b0;
      awA          <= {ADDR_W{1'b0}};
      wD           <= 32'h0;
      wS           <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
    end else begin
      if (s_axi_awvalid && !awHeld) begin
        awHeld <= 1'b1;
        awA    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld) begin
        wHeld <= 1'b1;
        wD    <= s_axi_wdata;
        wS    <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wrStb) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrErr ? 2'h2 : 2'h0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (rdStb) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdWord;
        s_axi_rresp  <= rdErr ? 2'h2 : 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/fess_hwrst.v
`timescale 1ns/1ps
`default_nettype none
`include "fess_map.vh"
module fess_hwrst (
  input  wire sys_clk,
  input  wire reset,
  input  wire hwResetN,
  input  wire busy,
  output wire hold,
  output wire freed,
  output reg  relBusy
);
  localparam integer IDLE_I = (`FESS_RST_IDLE_NS + `FESS_CLK_NS - 1) / `FESS_CLK_NS;
  localparam integer BUSY_I = (`FESS_RST_BUSY_NS + `FESS_CLK_NS - 1) / `FESS_CLK_NS;
  localparam [7:0]   IDLE_CYC = IDLE_I[7:0];
  localparam [7:0]   BUSY_CYC = BUSY_I[7:0];

  reg       pinS1;
  reg       pinS2;
  reg [7:0] lowCnt;
  reg       held;
  wire [7:0] need = busy ? BUSY_CYC : IDLE_CYC;

  assign hold    = held && !pinS2;
  assign freed   = held && pinS2;

  always @(posedge sys_clk) begin
    if (reset) begin
      pinS1   <= 1'b1;
      pinS2   <= 1'b1;
      lowCnt  <= 8'h0;
      held    <= 1'b0;
      relBusy <= 1'b0;
    end else begin
      pinS1 <= hwResetN;
      pinS2 <= pinS1;
      if (!pinS2) begin
        // a pulse shorter than the minimum width is not acted on
        if (!held) begin
          lowCnt <= lowCnt + 8'h1;
          if (lowCnt + 8'h1 >= need) begin
            held    <= 1'b1;
            relBusy <= busy;
          end
        end
      end else begin
        lowCnt <= 8'h0;
        held   <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/fess_sequencer.v
// How it works
// - chip erase starts after sixth write
// - chip erase programs zeros, then erases
// - 30h at even sector address opens window
// - more codes add sectors, restart window
// - window timer flag readable in selected sector
// - toggle freezes when time-limit flag sets
// - suspend B0h only during sector erase
// - suspended: foreign sectors readable, no programming
// - repeated suspend is ignored
// - suspend in window cancels, erase stopped
// - suspend during erase within 15 us
// - 30h resumes suspended erase
// - resume while erasing is ignored
// - idle hardware reset: 500 ns, quick read
// - busy hardware reset: 50 ns, 20 us reinit
// - reset mid operation marks data suspect
// - algorithm blocks reads, masks other interrupts
// - starts and returns to read state
// - commands ignored during word write
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "fess_map.vh"
module fess_sequencer #(
  parameter        ADDR_W    = 8,
  parameter        NSECT     = 8,
  parameter        SECT_SH   = 13,
  parameter [23:0] WIN_CYC   = `FESS_WIN_US * `FESS_CLK_MHZ,
  parameter [23:0] PRE_CYC   = `FESS_PRE_CYC,
  parameter [23:0] ERASE_CYC = `FESS_ERASE_CYC
) (
  input  wire              sys_clk,
  input  wire              reset,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output wire [1:0]        s_axi_bresp,
  output wire              s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output wire [31:0]       s_axi_rdata,
  output wire [1:0]        s_axi_rresp,
  output wire              s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              hwResetN,
  input  wire [7:0]        arrayData,
  input  wire              arrayFault,
  output reg  [15:0]       arrayAddr,
  output reg  [15:0]       opAddr,
  output reg  [7:0]        opData,
  output reg  [NSECT-1:0]  eraseSectors,
  output wire              arrayProgWord,
  output wire              arrayProgZero,
  output wire              arrayEraseRun,
  output wire              arrayReadBlock,
  output wire              otherIrqDisable,
  output wire              readReady,
  output reg               damaged
);
  localparam [3:0] S_READ   = 4'd0;
  localparam [3:0] S_PROG   = 4'd1;
  localparam [3:0] S_PRE    = 4'd2;
  localparam [3:0] S_CHIP   = 4'd3;
  localparam [3:0] S_SWAIT  = 4'd4;
  localparam [3:0] S_SERASE = 4'd5;
  localparam [3:0] S_SUSP   = 4'd6;
  localparam [3:0] S_STOP   = 4'd7;
  localparam [3:0] S_FAIL   = 4'd8;
  localparam [3:0] S_INIT   = 4'd9;

  localparam [23:0] PROG_CYC   = `FESS_PROG_CYC;
  localparam integer REINIT_I  = `FESS_REINIT_US * `FESS_CLK_MHZ;
  localparam [11:0] REINIT_CYC = REINIT_I[11:0];

  function [NSECT-1:0] sectOf;
    input [15:0] a;
    begin
      sectOf = {{(NSECT-1){1'b0}}, 1'b1} << (a >> SECT_SH);
    end
  endfunction

  wire              wrStb;
  wire [ADDR_W-1:0] wrAddr;
  wire [31:0]       wrData;
  wire [3:0]        wrStrb;
  wire              rdStb;
  wire [ADDR_W-1:0] rdAddr;
  reg  [31:0]       rdWord;
  reg               rdErr;
  reg               wrErr;
  wire              rstHold;
  wire              rstRel;
  wire              relBusy;

  reg  [3:0]  state;
  reg  [2:0]  step;
  reg  [23:0] tmr;
  reg  [11:0] initCnt;
  reg         togg;
  reg         stog;
  reg         failErase;
  reg  [7:0]  statByte;
  reg  [7:0]  rdByte;
  reg         showStat;
  reg         selHit;

  wire busy    = (state >= S_PROG) && (state <= S_SERASE);
  wire tmrRun  = busy && !rstHold;
  wire tmrZero = (tmr == 24'h0);
  wire parked  = (state == S_SUSP) || (state == S_STOP);
  wire algoRun = (state != S_READ) && (state != S_INIT);
  wire cmdGo   = wrStb && (wrAddr == `FESS_REG_CMD) && wrStrb[0];
  wire [7:0] cmdD = wrData[7:0];
  wire [15:0] cmdA = arrayAddr;
  wire rdGo    = rdStb && (rdAddr == `FESS_REG_RDATA);

  // a held hardware reset halts the array at once
  assign arrayProgWord   = (state == S_PROG) && !rstHold;
  assign arrayProgZero   = (state == S_PRE) && !rstHold;
  assign arrayEraseRun   = ((state == S_CHIP) || (state == S_SERASE)) && !rstHold;
  assign arrayReadBlock  = algoRun;
  assign otherIrqDisable = algoRun;
  assign readReady       = (state != S_INIT) && !rstHold;

  fess_axil #(
    .ADDR_W(ADDR_W)
  ) u_axil (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .s_axi_awaddr (s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata  (s_axi_wdata),
    .s_axi_wstrb  (s_axi_wstrb),
    .s_axi_wvalid (s_axi_wvalid),
    .s_axi_wready (s_axi_wready),
    .s_axi_bresp  (s_axi_bresp),
    .s_axi_bvalid (s_axi_bvalid),
    .s_axi_bready (s_axi_bready),
    .s_axi_araddr (s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata  (s_axi_rdata),
    .s_axi_rresp  (s_axi_rresp),
    .s_axi_rvalid (s_axi_rvalid),
    .s_axi_rready (s_axi_rready),
    .wrStb        (wrStb),
    .wrAddr       (wrAddr),
    .wrData       (wrData),
    .wrStrb       (wrStrb),
    .wrErr        (wrErr),
    .rdStb        (rdStb),
    .rdAddr       (rdAddr),
    .rdWord       (rdWord),
    .rdErr        (rdErr)
  );

  fess_hwrst u_hwrst (
    .sys_clk (sys_clk),
    .reset   (reset),
    .hwResetN(hwResetN),
    .busy    (busy),
    .hold    (rstHold),
    .freed   (rstRel),
    .relBusy (relBusy)
  );

  //////////////////////////////////////////////////////////////////////////////
  // status byte and read data
  always @* begin
    selHit   = |(sectOf(arrayAddr) & eraseSectors);
    showStat = (algoRun && !parked) || (parked && selHit);
    statByte = 8'h00;
    case (state)
      S_PROG: begin
        statByte[`FESS_B_POLL] = ~opData[7];
        statByte[`FESS_B_STOG] = 1'b1;
      end
      S_SUSP, S_STOP: begin
        statByte[`FESS_B_POLL] = 1'b1;
        statByte[`FESS_B_WIN]  = 1'b1;
      end
      S_FAIL: begin
        statByte[`FESS_B_POLL] = failErase ? 1'b0 : ~opData[7];
      end
      default: begin
        statByte[`FESS_B_POLL] = 1'b0;
        statByte[`FESS_B_WIN]  = (state != S_SWAIT);
      end
    endcase
    if (state != S_PROG) begin
      statByte[`FESS_B_STOG] = stog;
    end
    statByte[`FESS_B_TOGGLE] = togg;
    statByte[`FESS_B_TLIM]   = (state == S_FAIL);
    if (!readReady) begin
      rdByte = 8'h00;
    end else if (showStat) begin
      rdByte = statByte;
    end else begin
      rdByte = arrayData;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register decode
  always @* begin
    rdErr  = 1'b0;
    rdWord = 32'h0;
    if (rdAddr == `FESS_REG_ADDR) begin
      rdWord = {16'h0, arrayAddr};
    end else if (rdAddr == `FESS_REG_CMD) begin
      rdWord = 32'h0;
    end else if (rdAddr == `FESS_REG_RDATA) begin
      rdWord = {24'h0, rdByte};
    end else if (rdAddr == `FESS_REG_STATE) begin
      rdWord[`FESS_ST_CODE_LSB +: 4]     = state;
      rdWord[`FESS_ST_READY]             = readReady;
      rdWord[`FESS_ST_DAMAGED]           = damaged;
      rdWord[`FESS_ST_MASK_LSB +: NSECT] = eraseSectors;
    end else begin
      rdErr = 1'b1;
    end
    if (wrAddr == `FESS_REG_ADDR) begin
      wrErr = 1'b0;
    end else if (wrAddr == `FESS_REG_CMD) begin
      wrErr = 1'b0;
    end else begin
      wrErr = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  always @(posedge sys_clk) begin
    if (reset) begin
      state        <= S_READ;
      step         <= 3'd0;
      tmr          <= 24'h0;
      initCnt      <= 12'h0;
      togg         <= 1'b0;
      stog         <= 1'b0;
      failErase    <= 1'b0;
      arrayAddr    <= 16'h0;
      opAddr       <= 16'h0;
      opData       <= 8'h00;
      eraseSectors <= {NSECT{1'b0}};
      damaged      <= 1'b0;
    end else begin
      if (tmrRun && !tmrZero) begin
        tmr <= tmr - 24'h1;
      end
      if (initCnt != 12'h0) begin
        initCnt <= initCnt - 12'h1;
      end
      if (wrStb && (wrAddr == `FESS_REG_ADDR)) begin
        if (wrStrb[0]) begin
          arrayAddr[7:0] <= wrData[7:0];
        end
        if (wrStrb[1]) begin
          arrayAddr[15:8] <= wrData[15:8];
        end
      end
      if (rdGo && readReady && showStat) begin
        if (!parked && (state != S_FAIL)) begin
          togg <= ~togg;
        end
        if (selHit && (state != S_PROG)) begin
          stog <= ~stog;
        end
      end
      if (rstHold) begin
        state        <= S_READ;
        step         <= 3'd0;
        eraseSectors <= {NSECT{1'b0}};
      end else if (rstRel) begin
        if (relBusy) begin
          state   <= S_INIT;
          initCnt <= REINIT_CYC;
          damaged <= 1'b1;
        end else begin
          state <= S_READ;
        end
      end else begin
        case (state)
          S_READ: begin
            if (cmdGo) begin
              step <= 3'd0;
              if (cmdD == `FESS_CD_RESET) begin
                step <= 3'd0;
              end else if (step == 3'd0) begin
                if (cmdA == `FESS_UNLK_A1 && cmdD == `FESS_CD_UNLK1) begin
                  step <= 3'd1;
                end
              end else if (step == 3'd1 || step == 3'd4) begin
                if (cmdA == `FESS_UNLK_A2 && cmdD == `FESS_CD_UNLK2) begin
                  step <= step + 3'd1;
                end
              end else if (step == 3'd2) begin
                if (cmdA == `FESS_UNLK_A1 && cmdD == `FESS_CD_ERASE) begin
                  step <= 3'd3;
                end else if (cmdA == `FESS_UNLK_A1 && cmdD == `FESS_CD_PROG) begin
                  step <= 3'd6;
                end
              end else if (step == 3'd3) begin
                if (cmdA == `FESS_UNLK_A1 && cmdD == `FESS_CD_UNLK1) begin
                  step <= 3'd4;
                end
              end else if (step == 3'd5) begin
                if (cmdA == `FESS_UNLK_A1 && cmdD == `FESS_CD_CHIP) begin
                  state        <= S_PRE;
                  tmr          <= PRE_CYC;
                  eraseSectors <= {NSECT{1'b1}};
                end else if (cmdD == `FESS_CD_SECT && !cmdA[0]) begin
                  state        <= S_SWAIT;
                  tmr          <= WIN_CYC;
                  eraseSectors <= sectOf(cmdA);
                end
              end else if (step == 3'd6) begin
                state  <= S_PROG;
                tmr    <= PROG_CYC;
                opAddr <= cmdA;
                opData <= cmdD;
              end
            end
          end
          S_PROG: begin
            // every command falls through unseen here
            if (tmrZero) begin
              failErase <= 1'b0;
              state     <= arrayFault ? S_FAIL : S_READ;
            end
          end
          S_PRE: begin
            if (tmrZero) begin
              if (arrayFault) begin
                failErase <= 1'b1;
                state     <= S_FAIL;
              end else begin
                state <= S_CHIP;
                tmr   <= ERASE_CYC;
              end
            end
          end
          S_CHIP: begin
            if (tmrZero) begin
              failErase <= 1'b1;
              state     <= arrayFault ? S_FAIL : S_READ;
              if (!arrayFault) begin
                eraseSectors <= {NSECT{1'b0}};
              end
            end
          end
          S_SWAIT: begin
            if (cmdGo && cmdD == `FESS_CD_SUSP) begin
              state <= S_STOP;
            end else if (cmdGo && cmdD == `FESS_CD_SECT && !cmdA[0]) begin
              eraseSectors <= eraseSectors | sectOf(cmdA);
              tmr          <= WIN_CYC;
            end else if (tmrZero) begin
              state <= S_SERASE;
              tmr   <= ERASE_CYC;
            end
          end
          S_SERASE: begin
            if (cmdGo && cmdD == `FESS_CD_SUSP) begin
              state <= S_SUSP;
            end else if (tmrZero) begin
              failErase <= 1'b1;
              state     <= arrayFault ? S_FAIL : S_READ;
              if (!arrayFault) begin
                eraseSectors <= {NSECT{1'b0}};
              end
            end
          end
          S_SUSP: begin
            // further suspends and any program sequence are dropped
            if (cmdGo && cmdD == `FESS_CD_SECT) begin
              state <= S_SERASE;
            end
          end
          S_STOP: begin
            if (cmdGo && cmdD == `FESS_CD_SECT) begin
              state <= S_SERASE;
              tmr   <= ERASE_CYC;
            end else if (cmdGo && cmdD == `FESS_CD_RESET) begin
              state        <= S_READ;
              eraseSectors <= {NSECT{1'b0}};
            end
          end
          S_FAIL: begin
            if (cmdGo && cmdD == `FESS_CD_RESET) begin
              state        <= S_READ;
              step         <= 3'd0;
              eraseSectors <= {NSECT{1'b0}};
            end
          end
          S_INIT: begin
            if (initCnt == 12'h0) begin
              state <= S_READ;
            end
          end
          default: begin
            state <= S_READ;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/fess_seq_props.sv
`timescale 1ns/1ps
`default_nettype none
module fess_seq_props #(parameter NSECT = 8) (
  input wire logic             sys_clk,
  input wire logic             reset,
  input wire logic             hwResetN,
  input wire logic             arrayFault,
  input wire logic             s_axi_rvalid,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic [NSECT-1:0] eraseSectors,
  input wire logic             arrayProgWord,
  input wire logic             arrayProgZero,
  input wire logic             arrayEraseRun,
  input wire logic             arrayReadBlock,
  input wire logic             otherIrqDisable,
  input wire logic             readReady,
  input wire logic             damaged
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  chk_irq_mask: assert property (arrayReadBlock == otherIrqDisable)
    else $error("irq mask differs from read block");
  chk_erase_blocks: assert property (arrayEraseRun |-> arrayReadBlock)
    else $error("reads open during erase");
  chk_write_alone: assert property (arrayProgWord |-> arrayReadBlock && !arrayEraseRun && !arrayProgZero)
    else $error("word write overlaps other work");
  chk_chip_all: assert property ($rose(arrayProgZero) |-> &eraseSectors)
    else $error("zero phase without all sectors");
  chk_zero_then: assert property ($fell(arrayProgZero) && readReady && !$past(reset) && !$past(arrayFault)
    |-> arrayEraseRun)
    else $error("zero phase not followed by erase");
  chk_busy_ready: assert property (!readReady |-> !(arrayEraseRun || arrayProgWord || arrayProgZero))
    else $error("operation runs during reinit");
  chk_damage_sticky: assert property (damaged |=> damaged)
    else $error("damaged flag cleared");
  chk_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read bits set");
  cover property ($rose(arrayEraseRun));
  cover property ($fell(arrayEraseRun) && arrayReadBlock);
  cover property ($rose(damaged));
endmodule
`default_nettype wire

// >>> sim/fess_array_model.sv
`timescale 1ns/1ps
`default_nettype none
module fess_array_model (
  input  wire logic [15:0] arrayAddr,
  output wire logic [7:0]  arrayData
);
  // contents are a fixed pattern of the address
  assign arrayData = arrayAddr[7:0] ^ 8'h3c;
endmodule
`default_nettype wire

// >>> sim/flash_erase_suspend_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module flash_erase_suspend_sequencer_bench;
  logic        sys_clk, reset, hwResetN, arrayFault, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        arrayProgWord, arrayProgZero, arrayEraseRun, arrayReadBlock, otherIrqDisable, readReady, damaged;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, arrayData, opData, eraseSectors;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [15:0] arrayAddr, opAddr;
  logic [3:0]  s_axi_wstrb, mon;
  logic [1:0]  s_axi_bresp, s_axi_rresp, br;
  int          fail_count, cmp_count;
  assign mon = {readReady, arrayProgWord, arrayReadBlock, arrayEraseRun};
  fess_sequencer #(.WIN_CYC(24'd60), .PRE_CYC(24'd40), .ERASE_CYC(24'd100)) dut (.*);
  fess_array_model mdl (.arrayAddr(arrayAddr), .arrayData(arrayData));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    q = s_axi_rdata;
    s_axi_rready <= 1'b0;
    #1;
  endtask
  task cmd(input logic [15:0] a, input logic [7:0] d);
    wr(8'h00, {16'h0, a});
    wr(8'h04, {24'h0, d});
  endtask
  task stat(input logic [15:0] a);
    wr(8'h00, {16'h0, a});
    rd(8'h08);
  endtask
  task unl;
    cmd(16'h0aaa, 8'haa);
    cmd(16'h0554, 8'h55);
    cmd(16'h0aaa, 8'h80);
    cmd(16'h0aaa, 8'haa);
    cmd(16'h0554, 8'h55);
  endtask
  task wseq(input logic [15:0] a, input logic [7:0] d);
    cmd(16'h0aaa, 8'haa);
    cmd(16'h0554, 8'h55);
    cmd(16'h0aaa, 8'ha0);
    cmd(a, d);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task wt(input int k, input logic v);
    int n;
    n = 0;
    while (mon[k] !== v && n < 5000) begin
      @(posedge sys_clk);
      n++;
    end
    #1;
    if (n >= 5000) fail_count++;
  endtask
  task pin(input logic v, input int n);
    @(posedge sys_clk);
    hwResetN <= v;
    cyc(n);
  endtask
  ////////////////////////////////////////////////////////////
  task t_bus;
    wr(8'h00, 32'h0000_1234);
    rd(8'h00);
    chk(q, 32'h1234);
    wr(8'h10, 32'h0);
    chk(br, 2'b10);
    rd(8'h10);
    chk(q, 32'h0);
    chk(s_axi_rresp, 2'b10);
  endtask
  task t_chip;
    unl();
    chk(arrayReadBlock, 1'b0);
    cmd(16'h0aaa, 8'h10);
    chk(arrayProgZero, 1'b1);
    chk(eraseSectors, 8'hff);
    cmd(16'h0000, 8'hb0);
    chk(arrayProgZero, 1'b1);
    wt(0, 1'b1);
    wt(1, 1'b0);
    chk(mon[1:0], 2'b00);
  endtask
  task t_window;
    unl();
    cmd(16'h2000, 8'h30);
    cmd(16'h4000, 8'h30);
    stat(16'h2000);
    chk(q[3], 1'b0);
    chk({eraseSectors, arrayEraseRun}, 9'h00c);
    cmd(16'h0000, 8'hb0);
    cyc(70);
    chk(mon[1:0], 2'b10);
    stat(16'h2000);
    chk(q[7], 1'b1);
    cmd(16'h0000, 8'hf0);
    chk(arrayReadBlock, 1'b0);
  endtask
  task t_susp;
    unl();
    cmd(16'h2000, 8'h30);
    wt(0, 1'b1);
    cmd(16'h0000, 8'hb0);
    chk(mon[1:0], 2'b10);
    cmd(16'h0000, 8'hb0);
    chk(mon[1:0], 2'b10);
    stat(16'h0010);
    chk(q, 32'h2c);
    wseq(16'h0010, 8'h00);
    chk(arrayProgWord, 1'b0);
    cmd(16'h0000, 8'h30);
    chk(arrayEraseRun, 1'b1);
    cmd(16'h0000, 8'h30);
    chk(arrayEraseRun, 1'b1);
    wt(1, 1'b0);
  endtask
  task t_write;
    wseq(16'h0100, 8'h5a);
    chk({opAddr, opData}, 24'h01005a);
    cmd(16'h0000, 8'hb0);
    chk(mon[2:0], 3'b110);
    stat(16'h0100);
    chk({q[7], q[5]}, 2'b10);
    @(posedge sys_clk);
    arrayFault <= 1'b1;
    wt(2, 1'b0);
    stat(16'h0100);
    br = {q[6], q[5]};
    rd(8'h08);
    chk({q[7], q[5]}, 2'b11);
    chk(q[6], br[1]);
    chk(br[0], 1'b1);
    @(posedge sys_clk);
    arrayFault <= 1'b0;
    cmd(16'h0000, 8'hf0);
    chk(arrayReadBlock, 1'b0);
  endtask
  task t_hwrst;
    pin(1'b0, 60);
    chk(readReady, 1'b0);
    pin(1'b1, 50);
    chk({readReady, damaged}, 2'b10);
    wseq(16'h0200, 8'h00);
    pin(1'b0, 12);
    chk(readReady, 1'b0);
    pin(1'b1, 3);
    chk({readReady, damaged}, 2'b01);
    wt(3, 1'b1);
  endtask
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {reset, hwResetN, s_axi_wstrb} = 6'h3f;
    {arrayFault, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    fail_count = 0;
    cmp_count = 0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    t_bus();
    t_chip();
    t_window();
    t_susp();
    t_write();
    t_hwrst();
    end_sim();
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    fail_count++;
    end_sim();
  end
endmodule
bind fess_sequencer fess_seq_props #(.NSECT(NSECT)) props (.*);
`default_nettype wire
